/* File: core/dcs_ctrl.sv */
// DDR3 command and clock-enable sequencer on the controller side
`timescale 1ns/100ps
`include "dcs_cfg.svh"
module dcs_ctrl #(
  parameter int NBANK = 8,
  parameter int TXSDLL = `DCS_TXSDLL_NCK
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire dcs_pkg::dcs_cmd_t req_cmd_in,
  input wire logic [2:0] req_ba_in,
  input wire logic [15:0] req_addr_in,
  input wire dcs_pkg::dcs_pwr_t pwr_req_in,
  input wire logic pwr_exit_in,
  output logic req_ready_out,
  output logic ddr_reset_n_out,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic cke_out,
  output logic [2:0] ba_out,
  output logic [15:0] addr_out,
  output logic odt_out,
  output logic in_pd_out,
  output logic in_sr_out,
  output logic idle_out,
  output logic [NBANK-1:0] bank_open_out
);
  typedef enum logic [4:0] {
    DCS_ST_IDLE = 5'h01,
    DCS_ST_BUSY = 5'h02,
    DCS_ST_PD = 5'h04,
    DCS_ST_SR = 5'h08,
    DCS_ST_EXIT = 5'h10
  } dcs_state_t;

  dcs_state_t state_r;
  logic [9:0] wait_r;
  logic [9:0] wr_wait_r;
  logic [9:0] rd_wait_r;
  logic [3:0] cke_hold_r;
  logic [NBANK-1:0] open_r;
  logic cke_r;
  dcs_pin_if pin ();

  // Clock enable must be back high before any command or power request is issued
  wire logic timers_done = (wait_r == 10'h000) && (cke_hold_r == 4'h0) && cke_r;
  wire logic is_rw = (req_cmd_in == dcs_pkg::DCS_CMD_RD) || (req_cmd_in == dcs_pkg::DCS_CMD_WR);
  wire logic rw_block = (req_cmd_in == dcs_pkg::DCS_CMD_WR && wr_wait_r != 10'h000)
    || (req_cmd_in == dcs_pkg::DCS_CMD_RD && rd_wait_r != 10'h000); // [R8] [R13]
  wire logic cmd_take = (state_r == DCS_ST_IDLE) && req_valid_in && timers_done && !rw_block
    && pwr_req_in == dcs_pkg::DCS_REQ_NONE;
  wire logic all_closed = (open_r == '0);
  // Self refresh only from all banks idle with nothing pending
  wire logic sr_go = (state_r == DCS_ST_IDLE) && timers_done && all_closed
    && pwr_req_in == dcs_pkg::DCS_REQ_SR; // [R14] [R15] [R18]
  // Power-down after timing settles; refresh is the caller's duty outside it
  wire logic pd_go = (state_r == DCS_ST_IDLE) && timers_done
    && pwr_req_in == dcs_pkg::DCS_REQ_PD; // [R5] [R10] [R17]
  wire logic exit_go = (state_r == DCS_ST_PD || state_r == DCS_ST_SR) && pwr_exit_in
    && cke_hold_r == 4'h0; // [R16]

  // Per-command busy time after issue
  function automatic logic [9:0] dcs_delay(input dcs_pkg::dcs_cmd_t c);
    unique case (c)
      dcs_pkg::DCS_CMD_MRS: dcs_delay = 10'(`DCS_TMOD_NCK);
      dcs_pkg::DCS_CMD_REF: dcs_delay = 10'(`DCS_TRFC_NCK);
      dcs_pkg::DCS_CMD_PRE: dcs_delay = 10'(`DCS_TRP_NCK);
      dcs_pkg::DCS_CMD_ACT: dcs_delay = 10'(`DCS_TRCD_NCK);
      dcs_pkg::DCS_CMD_ZQ: dcs_delay = 10'(`DCS_TZQ_NCK);
      dcs_pkg::DCS_CMD_RD, dcs_pkg::DCS_CMD_WR: dcs_delay = 10'(`DCS_TBURST_NCK);
      default: dcs_delay = 10'h000;
    endcase
  endfunction : dcs_delay

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= DCS_ST_IDLE;
    end else begin
      unique case (state_r)
        DCS_ST_IDLE: begin
          if (sr_go) state_r <= DCS_ST_SR;
          else if (pd_go) state_r <= DCS_ST_PD;
          else if (cmd_take) state_r <= DCS_ST_BUSY;
        end
        // Bursts are never cut: wait out the full busy time
        // Zero-delay commands such as NOP leave after one cycle instead of sticking
        DCS_ST_BUSY: if (wait_r <= 10'h001) state_r <= DCS_ST_IDLE; // [R4] [R9]
        DCS_ST_PD, DCS_ST_SR: if (exit_go) state_r <= DCS_ST_EXIT;
        DCS_ST_EXIT: if (wait_r == 10'h001) state_r <= DCS_ST_IDLE; // [R13]
        default: state_r <= DCS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wait_r <= 10'h000;
    end else if (cmd_take) begin
      wait_r <= dcs_delay(req_cmd_in);
    end else if (exit_go) begin
      wait_r <= (state_r == DCS_ST_SR) ? 10'(`DCS_TXS_NCK) : 10'(`DCS_TXP_NCK);
    end else if (wait_r != 10'h000) begin
      wait_r <= wait_r - 10'h001;
    end
  end

  // Write and read lockouts after self-refresh exit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_wait_r <= 10'h000;
      rd_wait_r <= 10'h000;
    end else if (exit_go && state_r == DCS_ST_SR) begin
      wr_wait_r <= 10'(TXSDLL); // [R8]
      rd_wait_r <= 10'(TXSDLL); // [R13]
    end else begin
      if (wr_wait_r != 10'h000) wr_wait_r <= wr_wait_r - 10'h001;
      if (rd_wait_r != 10'h000) rd_wait_r <= rd_wait_r - 10'h001;
    end
  end

  // Clock-enable level with minimum pulse hold
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cke_r <= 1'b0;
      cke_hold_r <= 4'h0;
    end else if (sr_go || pd_go || exit_go) begin
      cke_r <= exit_go; // [R7] [R16]
      cke_hold_r <= 4'(`DCS_TCKE_NCK - 1);
    end else begin
      if (!cke_r && state_r == DCS_ST_IDLE) cke_r <= 1'b1;
      if (cke_hold_r != 4'h0) cke_hold_r <= cke_hold_r - 4'h1;
    end
  end

  // Bank open flags; auto-precharge clears the flag when the read or write is taken
  generate
    for (genvar b = 0; b < NBANK; b++) begin : g_bank
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          open_r[b] <= 1'b0;
        end else if (cmd_take && (req_ba_in == 3'(b) || req_cmd_in == dcs_pkg::DCS_CMD_PRE)) begin
          unique case (req_cmd_in)
            dcs_pkg::DCS_CMD_ACT: open_r[b] <= 1'b1; // [R22]
            dcs_pkg::DCS_CMD_PRE:
              if (req_addr_in[`DCS_A10_BIT] || req_ba_in == 3'(b)) open_r[b] <= 1'b0; // [R21] [R22]
            dcs_pkg::DCS_CMD_RD, dcs_pkg::DCS_CMD_WR:
              if (req_addr_in[`DCS_A10_BIT]) open_r[b] <= 1'b0; // [R22]
            default: open_r[b] <= open_r[b];
          endcase
        end
      end
    end
  endgenerate

  // Status outputs and pin load; power-down entry and both exit edges carry only NOP, self-refresh entry carries refresh
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_ready_out <= 1'b0;
      ddr_reset_n_out <= 1'b1; // [R2]
      odt_out <= 1'b0;
      in_pd_out <= 1'b0;
      in_sr_out <= 1'b0;
      idle_out <= 1'b0;
      bank_open_out <= '0;
    end else begin
      req_ready_out <= cmd_take;
      ddr_reset_n_out <= 1'b1; // [R2]
      odt_out <= 1'b0; // [R6]
      in_pd_out <= (state_r == DCS_ST_PD);
      in_sr_out <= (state_r == DCS_ST_SR);
      idle_out <= (state_r == DCS_ST_IDLE) && timers_done && all_closed && cke_r; // [R18]
      bank_open_out <= open_r;
    end
  end

  // Self-refresh entry is a refresh with clock enable falling; a taken request drives its own command, every other edge is NOP
  assign pin.cmd = cmd_take ? req_cmd_in
    : (sr_go ? dcs_pkg::DCS_CMD_REF : dcs_pkg::DCS_CMD_NOP); // [R11] [R12] [R19] [R20]
  assign pin.cke = (sr_go || pd_go) ? 1'b0 : (exit_go ? 1'b1 : cke_r);
  assign pin.ba = req_ba_in;
  assign pin.addr = req_addr_in;
  assign pin.load = 1'b1;

  dcs_pin_drv u_drv (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin(pin),
    .cs_n_out(cs_n_out),
    .ras_n_out(ras_n_out),
    .cas_n_out(cas_n_out),
    .we_n_out(we_n_out),
    .cke_out(cke_out),
    .ba_out(ba_out),
    .addr_out(addr_out)
  );

  AST_SR_EXIT_NOP: assert property (@(posedge clk_in) disable iff (rst_in)
    exit_go |=> (cke_out && ras_n_out && cas_n_out && we_n_out)) else $error("exit edge not NOP"); // [R12]
  AST_PD_ENTRY: assert property (@(posedge clk_in) disable iff (rst_in)
    pd_go |=> (!cke_out && ras_n_out)) else $error("power-down entry not NOP"); // [R11]
  AST_SR_IDLE: assert property (@(posedge clk_in) disable iff (rst_in)
    sr_go |=> (!cke_out && {cs_n_out, ras_n_out, cas_n_out, we_n_out} == 4'h1 && bank_open_out == '0))
    else $error("self refresh entry not a refresh with banks closed"); // [R14]
  AST_RD_LOCK: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_wait_r != 10'h000) |=> !(!cs_n_out && {ras_n_out, cas_n_out, we_n_out} == 3'h5))
    else $error("read too early"); // [R13]
  AST_NONIDLE_NOP: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_r == DCS_ST_BUSY || state_r == DCS_ST_EXIT) |=> (cs_n_out || {ras_n_out, cas_n_out, we_n_out} == 3'h7))
    else $error("command issued while busy or exiting"); // [R13]
  AST_ODT_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    in_sr_out |-> !odt_out) else $error("termination during self refresh"); // [R6]
endmodule : dcs_ctrl

/* File: core/dcs_cfg.svh */
// Timing and encoding constants for the DDR3 command sequencer
// Notes on behaviour
// [R1] Device decodes CS#, RAS#, CAS#, WE#, CKE together on the rising clock edge.
// [R2] Reset pin is asynchronous active low; controller holds it high in normal use.
// [R3] Bank address picks the bank, or the mode register for mode register set.
// [R4] Started read or write bursts run to completion without interruption.
// [R5] No refresh happens in power-down; controller refreshes outside it.
// [R6] Termination input never steers state; termination off during self refresh.
// [R7] Self-refresh exit is recognised asynchronously when clock enable rises.
// [R8] Controller waits 512 clocks after self-refresh exit before first write.
// [R9] NOP and deselect register nothing and never cut an operation short.
// [R10] Clock enable may drop only after mode register spacing and update delay.
// [R11] Power-down entry and exit edges carry only NOP or deselect.
// [R12] Self-refresh exit edge carries only NOP or deselect.
// [R13] Only NOP or deselect during exit delay; reads after DLL exit delay.
// [R14] Self refresh entered only from all-idle via refresh with clock enable falling.
// [R15] Controller never enters self refresh during a read or write.
// [R16] Clock enable level held for the minimum pulse time before changing again. The controller loads no hold on its first rise after reset.
// [R17] Power-down type follows bank state: closed gives precharge, open gives active.
// [R18] Idle means banks closed, no burst, clock enable high, timings elapsed.
// [R19] Controller produces only listed state, clock-enable and command combinations.
// [R20] Command and address pins are ignored while clock enable stays low.
// [R21] Commands use standard RAS#, CAS#, WE# coding; A10 selects auto-precharge or all.
// [R22] Per-bank open flag kept, updated by activate, precharge and auto-precharge.
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH
`define DCS_CLK_MHZ 200
`define DCS_TCKE_NCK 3
`define DCS_TMRD_NCK 4
`define DCS_TMOD_NCK 12
`define DCS_TXS_NCK 64
`define DCS_TXSDLL_NCK 512
`define DCS_TXP_NCK 3
`define DCS_TRP_NCK 11
`define DCS_TRCD_NCK 11
`define DCS_TRFC_NCK 52
`define DCS_TZQ_NCK 64
`define DCS_TBURST_NCK 16
`define DCS_A10_BIT 10
`define DCS_A12_BIT 12
`endif

/* File: core/dcs_pkg.sv */
// Types shared by the command sequencer files
package dcs_pkg;
  typedef enum logic [3:0] {
    DCS_CMD_NOP = 4'h7,
    DCS_CMD_MRS = 4'h0,
    DCS_CMD_REF = 4'h1,
    DCS_CMD_PRE = 4'h2,
    DCS_CMD_ACT = 4'h3,
    DCS_CMD_WR = 4'h4,
    DCS_CMD_RD = 4'h5,
    DCS_CMD_ZQ = 4'h6,
    DCS_CMD_DES = 4'hF
  } dcs_cmd_t;
  typedef enum logic [1:0] {
    DCS_REQ_NONE = 2'h0,
    DCS_REQ_PD = 2'h1,
    DCS_REQ_SR = 2'h2
  } dcs_pwr_t;
endpackage : dcs_pkg

/* File: core/dcs_pin_if.sv */
// Command pin bundle between the sequencer and its pin driver
`timescale 1ns/100ps
interface dcs_pin_if;
  dcs_pkg::dcs_cmd_t cmd;
  logic cke;
  logic [2:0] ba;
  logic [15:0] addr;
  logic load;
  modport src (output cmd, cke, ba, addr, load);
  modport dst (input cmd, cke, ba, addr, load);
endinterface : dcs_pin_if

/* File: core/dcs_pin_drv.sv */
// Registers the command onto the DDR3 command pins
`timescale 1ns/100ps
module dcs_pin_drv (
  input wire logic clk_in,
  input wire logic rst_in,
  dcs_pin_if.dst pin,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic cke_out,
  output logic [2:0] ba_out,
  output logic [15:0] addr_out
);
  // Maps a command code to its CS#, RAS#, CAS#, WE# levels
  function automatic logic [3:0] dcs_code(input dcs_pkg::dcs_cmd_t c);
    unique case (c)
      dcs_pkg::DCS_CMD_MRS: dcs_code = 4'h0;
      dcs_pkg::DCS_CMD_REF: dcs_code = 4'h1;
      dcs_pkg::DCS_CMD_PRE: dcs_code = 4'h2;
      dcs_pkg::DCS_CMD_ACT: dcs_code = 4'h3;
      dcs_pkg::DCS_CMD_WR: dcs_code = 4'h4;
      dcs_pkg::DCS_CMD_RD: dcs_code = 4'h5;
      dcs_pkg::DCS_CMD_ZQ: dcs_code = 4'h6;
      dcs_pkg::DCS_CMD_NOP: dcs_code = 4'h7;
      default: dcs_code = 4'hF;
    endcase
  endfunction : dcs_code

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'hF;
      cke_out <= 1'b0;
      ba_out <= 3'h0;
      addr_out <= 16'h0000;
    end else if (pin.load) begin
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= dcs_code(pin.cmd); // [R21]
      cke_out <= pin.cke; // [R1]
      ba_out <= pin.ba; // [R3]
      addr_out <= pin.addr;
    end
  end
endmodule : dcs_pin_drv

/* File: dv/dcs_dev_model.sv */
// Behavioural DDR3 device that tracks bank and power state and flags command sequencing faults
`timescale 1ns/100ps
module dcs_dev_model #(
  parameter int TWR_SRX = 512,
  parameter int TXS = 64,
  parameter int TCKE = 3
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic cke_in,
  input wire logic [2:0] ba_in,
  input wire logic [15:0] addr_in,
  input wire logic odt_in,
  output logic [7:0] open_out,
  output logic sr_out,
  output logic pd_out,
  output logic pd_act_out,
  output int viol_out
);
  logic cke_r;
  logic [3:0] c;
  logic quiet;
  int xs_r;
  int ck_r;
  assign c = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  assign quiet = cs_n_in || c == 4'h7;
  // Termination input is never read: it cannot steer state
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cke_r <= 1'b0;
      open_out <= 8'h00;
      sr_out <= 1'b0;
      pd_out <= 1'b0;
      pd_act_out <= 1'b0;
      viol_out <= 0;
      xs_r <= TWR_SRX;
      ck_r <= TCKE;
    end else begin
      cke_r <= cke_in;
      ck_r <= (cke_in != cke_r) ? 0 : ck_r + 1;
      if (cke_in != cke_r && ck_r < TCKE - 1) viol_out <= viol_out + 1;
      if (xs_r < TWR_SRX) xs_r <= xs_r + 1;
      if (cke_r && cke_in) begin
        if ((xs_r < TXS && !quiet) || (xs_r < TWR_SRX && c == 4'h4)) viol_out <= viol_out + 1;
        case (c)
          4'h3: open_out[ba_in] <= 1'b1;
          4'h2: if (addr_in[10]) open_out <= 8'h00; else open_out[ba_in] <= 1'b0;
          // Bursts are never cut short; auto-precharge closes the bank on the read or write command edge
          4'h4, 4'h5: if (addr_in[10]) open_out[ba_in] <= 1'b0;
          default: ;
        endcase
      end else if (cke_r && !cke_in) begin
        if (c == 4'h1) begin
          sr_out <= 1'b1;
          if (|open_out) viol_out <= viol_out + 1;
        end else if (quiet) begin
          pd_out <= 1'b1;
          pd_act_out <= |open_out;
        end else viol_out <= viol_out + 1;
      end else if (!cke_r && cke_in) begin
        if (!quiet) viol_out <= viol_out + 1;
        if (sr_out) xs_r <= 0;
        sr_out <= 1'b0;
        pd_out <= 1'b0;
      end
    end
  end
endmodule : dcs_dev_model

/* File: dv/dcs_ctrl_test.sv */
// Self-checking bench for the command and clock-enable sequencer
`timescale 1ns/100ps
`include "dcs_cfg.svh"
module dcs_ctrl_test;
  localparam int TXSDLL = 512;
  typedef struct {dcs_pkg::dcs_cmd_t cmd; logic [2:0] ba; logic [15:0] addr; logic [7:0] open;} dcs_row_t;
  logic clk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0, pwr_exit_in = 1'b0;
  dcs_pkg::dcs_cmd_t req_cmd_in = dcs_pkg::DCS_CMD_NOP;
  dcs_pkg::dcs_pwr_t pwr_req_in = dcs_pkg::DCS_REQ_NONE;
  logic [2:0] req_ba_in = 3'h0, ba_out;
  logic [15:0] req_addr_in = 16'h0000, addr_out;
  logic req_ready_out, ddr_reset_n_out, cs_n_out, ras_n_out, cas_n_out, we_n_out, cke_out, odt_out;
  logic in_pd_out, in_sr_out, idle_out, m_sr, m_pd, m_pda;
  logic [7:0] bank_open_out, m_open;
  int m_viol, failures = 0, comparisons = 0, cyc = 0, t0, rdy;
  dcs_row_t rows[10] = '{
    '{dcs_pkg::DCS_CMD_ACT, 3'h2, 16'h0000, 8'h04}, '{dcs_pkg::DCS_CMD_WR, 3'h2, 16'h0000, 8'h04},
    '{dcs_pkg::DCS_CMD_ACT, 3'h5, 16'h0000, 8'h24}, '{dcs_pkg::DCS_CMD_RD, 3'h5, 16'h0400, 8'h04},
    '{dcs_pkg::DCS_CMD_MRS, 3'h3, 16'h0000, 8'h04}, '{dcs_pkg::DCS_CMD_ZQ, 3'h0, 16'h0400, 8'h04},
    '{dcs_pkg::DCS_CMD_PRE, 3'h2, 16'h0000, 8'h00}, '{dcs_pkg::DCS_CMD_ACT, 3'h7, 16'h0000, 8'h80},
    '{dcs_pkg::DCS_CMD_PRE, 3'h0, 16'h0400, 8'h00}, '{dcs_pkg::DCS_CMD_REF, 3'h0, 16'h0000, 8'h00}};
  dcs_ctrl #(.NBANK(8), .TXSDLL(TXSDLL)) DUT (.clk_in, .rst_in, .req_valid_in, .req_cmd_in, .req_ba_in,
    .req_addr_in, .pwr_req_in, .pwr_exit_in, .req_ready_out, .ddr_reset_n_out, .cs_n_out, .ras_n_out,
    .cas_n_out, .we_n_out, .cke_out, .ba_out, .addr_out, .odt_out, .in_pd_out, .in_sr_out, .idle_out,
    .bank_open_out);
  // Full DLL exit delay kept so the read lockout outlasts the exit delay and is really exercised
  dcs_dev_model #(.TWR_SRX(TXSDLL), .TXS(`DCS_TXS_NCK), .TCKE(3)) model (.clk_in,
    .reset_n_in(ddr_reset_n_out && !rst_in),
    .cs_n_in(cs_n_out), .ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .we_n_in(we_n_out), .cke_in(cke_out),
    .ba_in(ba_out), .addr_in(addr_out), .odt_in(odt_out), .open_out(m_open), .sr_out(m_sr), .pd_out(m_pd),
    .pd_act_out(m_pda), .viol_out(m_viol));
  initial forever #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;
  task check(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask : check
  task finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic wait_on(ref logic s, input logic v);
    for (int k = 0; k < 1000 && s !== v; k++) @(negedge clk_in);
    check("wait", v, s);
  endtask : wait_on
  task send(input dcs_row_t r);
    @(negedge clk_in);
    req_cmd_in = r.cmd;
    req_ba_in = r.ba;
    req_addr_in = r.addr;
    req_valid_in = 1'b1;
    wait_on(req_ready_out, 1'b1);
    rdy = cyc;
    req_valid_in = 1'b0;
    // Ready is a one-cycle pulse; bank flags have settled once it falls
    wait_on(req_ready_out, 1'b0);
  endtask : send
  task automatic power(input dcs_pkg::dcs_pwr_t p, ref logic s);
    @(negedge clk_in);
    pwr_req_in = p;
    wait_on(s, 1'b1);
    pwr_req_in = dcs_pkg::DCS_REQ_NONE;
    repeat (6) @(negedge clk_in);
    pwr_exit_in = 1'b1;
    wait_on(s, 1'b0);
    t0 = cyc;
    pwr_exit_in = 1'b0;
  endtask : power
  initial begin
    repeat (12) @(negedge clk_in);
    check("cke in reset", 1'b0, cke_out);
    rst_in = 1'b0;
    wait_on(idle_out, 1'b1);
    check("reset pin", 1'b1, ddr_reset_n_out);
    foreach (rows[i]) begin
      send(rows[i]);
      check("bank_open", rows[i].open, bank_open_out);
      check("device banks", rows[i].open, m_open);
    end
    send('{dcs_pkg::DCS_CMD_ACT, 3'h1, 16'h0000, 8'h02});
    power(dcs_pkg::DCS_REQ_PD, in_pd_out);
    check("active pd", 1'b1, m_pda);
    check("banks after pd", 8'h02, bank_open_out);
    send('{dcs_pkg::DCS_CMD_PRE, 3'h0, 16'h0400, 8'h00});
    wait_on(idle_out, 1'b1);
    @(negedge clk_in);
    pwr_req_in = dcs_pkg::DCS_REQ_SR;
    wait_on(in_sr_out, 1'b1);
    check("device in sr", 1'b1, m_sr);
    check("odt in sr", 1'b0, odt_out);
    pwr_req_in = dcs_pkg::DCS_REQ_NONE;
    power(dcs_pkg::DCS_REQ_NONE, in_sr_out);
    wait_on(idle_out, 1'b1);
    send('{dcs_pkg::DCS_CMD_ACT, 3'h0, 16'h0000, 8'h01});
    send('{dcs_pkg::DCS_CMD_RD, 3'h0, 16'h0000, 8'h01});
    check("read after sr exit", 1'b1, (rdy - t0) >= TXSDLL);
    check("device faults before reset", 0, m_viol);
    @(negedge clk_in);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check("cke mid reset", 1'b0, cke_out);
    check("des mid reset", 1'b1, cs_n_out);
    rst_in = 1'b0;
    wait_on(idle_out, 1'b1);
    check("banks after reset", 8'h00, bank_open_out);
    check("device faults", 0, m_viol);
    finish_test();
  end
  // Whole run needs about a thousand cycles; 40000 leaves ample margin
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule : dcs_ctrl_test
